// ===== pswd_params.svh
`ifndef PSWD_PARAMS_SVH
`define PSWD_PARAMS_SVH

// ==========================================================
// Register byte addresses (AHB-Lite word per register)
// ==========================================================
`define PSWD_ADDR_W 8
`define PSWD_POWER_CONTROL_IDX 8'h87
`define PSWD_OFF_POWER_CONTROL 8'h1C
`define PSWD_OFF_RELOAD 8'h20
`define PSWD_OFF_WDCTL 8'h24
`define PSWD_OFF_STATUS 8'h28
`define PSWD_OFF_COUNT 8'h2C

// ==========================================================
// Power control bit positions
// ==========================================================
`define PSWD_BIT_IDLE 0
`define PSWD_BIT_PDE 1
`define PSWD_BIT_GF0 2
`define PSWD_BIT_GF1 3
`define PSWD_BIT_SD 4
`define PSWD_BIT_IDLE_START_BIT 5
`define PSWD_BIT_PDS 6
`define PSWD_BIT_SERIAL_RATE_DOUBLE_BIT 7
// Bits that store (all except the self-clearing ones)
`define PSWD_POWER_CONTROL_KEEP 8'h9C

// ==========================================================
// Watchdog control bits and timing
// ==========================================================
`define PSWD_BIT_REFRESH 0
`define PSWD_BIT_START 1
`define PSWD_BIT_PRESC 7
`define PSWD_CYCLE_DIV 12
`define PSWD_SD_DIV 8
`define PSWD_PRE16 16
`define PSWD_TIMEOUT 15'h7FFC
`define PSWD_RST_SHORT 8
`define PSWD_RST_LONG 128
`define PSWD_SD_SYNC 2
`define PSWD_REFRESH_LIFE 2

`endif

// ===== pswd_pkg.sv
package pswd_pkg;
	// Power state of the core
	typedef enum logic [1:0] {PS_RUN, PS_IDLE, PS_DOWN} pswd_pstate_type;
	// AHB-Lite request bundle
	typedef struct packed {
		logic hsel;
		logic [31:0] haddr;
		logic [1:0] htrans;
		logic hwrite;
		logic [2:0] hsize;
		logic hready;
	} pswd_ahb_req_type;
	// Pin-facing outputs
	typedef struct packed {
		logic core_clk_en;
		logic osc_stop;
		logic hold_outputs;
		logic ale_force_low;
		logic program_store_strobe_force_low;
		logic clock_output_pin_force_low;
		logic idle_active;
		logic slow_active;
	} pswd_pins_type;
endpackage

// ===== pswd_ctrl.sv
`timescale 1ns/100ps
`include "pswd_params.svh"

module pswd_ctrl (
	input wire logic hclk, // Oscillator-rate clock
	input wire logic hresetn, // External hardware reset, active low
	input wire pswd_pkg::pswd_ahb_req_type ahb_req, // AHB address phase
	input wire logic [31:0] hwdata, // Write data
	output logic [31:0] hrdata, // Read data
	output logic hreadyout, // Always ready
	output logic hresp, // Always OKAY
	input wire logic powersave_gate_pin, // Gate pin, high blocks saving
	output pswd_pkg::pswd_pins_type pins, // Power control to the core
	output logic machine_cycle_tick, // One pulse per machine cycle
	output logic watchdog_reset_out // Internal reset from time-out
);
	import pswd_pkg::*;

	// ======================================================
	// Bus slave
	// ======================================================
	logic wr_pend_reg; // Write data phase pending
	logic [7:0] wr_addr_reg; // Latched write offset
	logic [31:0] hrdata_reg; // Registered read data
	// Only NONSEQ and SEQ start a transfer; IDLE and BUSY are ignored
	wire addr_phase = ahb_req.hsel & ahb_req.htrans[1] & ahb_req.hready;
	wire wr_start = addr_phase & ahb_req.hwrite;
	wire rd_start = addr_phase & ~ahb_req.hwrite;
	wire [7:0] rd_addr = ahb_req.haddr[7:0];
	wire wr_power_control = wr_pend_reg & (wr_addr_reg == `PSWD_OFF_POWER_CONTROL);
	wire wr_reload = wr_pend_reg & (wr_addr_reg == `PSWD_OFF_RELOAD);
	wire wr_wdctl = wr_pend_reg & (wr_addr_reg == `PSWD_OFF_WDCTL);
	wire [7:0] wbyte = hwdata[7:0];

	// Zero wait states: every register answers in its data phase
	// No error response; unmapped offsets read zero and drop writes
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_reg;

	// Capture write address for the data phase
	// Offset latched every cycle; only the pending flag qualifies it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
		end else begin
			wr_pend_reg <= wr_start;
			wr_addr_reg <= ahb_req.haddr[7:0];
		end
	end

	// ======================================================
	// Strap capture at reset release
	// ======================================================
	// Strap taken once per reset, from the first clock after release
	logic strap_done_reg; // First edge after release seen
	logic hw_autostart_reg; // Gate pin high at the first edge after release
	// Later pin changes never reach the watchdog, only the saving gate
	// Pin sampled on first edge after release, with the core already in PS_RUN
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			strap_done_reg <= 1'b0;
			hw_autostart_reg <= 1'b0;
		end else if (!strap_done_reg) begin
			strap_done_reg <= 1'b1;
			hw_autostart_reg <= powersave_gate_pin;
		end
	end
	// Saving is blocked by live pin or by autostart strap
	// The strap keeps saving locked out until the next reset
	wire save_allowed = ~powersave_gate_pin & ~hw_autostart_reg;

	// ======================================================
	// Machine cycle and slow-down
	// ======================================================
	// Twelve oscillator clocks make one machine cycle; slow-down then
	// stretches the cycle tick, so every tick user slows down together
	logic [3:0] osc_div_reg; // Oscillator to machine cycle
	logic [2:0] slow_div_reg; // Extra divide by eight
	logic [1:0] sd_sync_reg; // Slow-down engage pipeline
	pswd_pstate_type pstate_reg, pstate_next; // Power state
	logic [7:0] power_control_reg; // Stored power control bits
	logic slow_active;
	wire osc_running = (pstate_reg != PS_DOWN);
	wire osc_wrap = (osc_div_reg == 4'(`PSWD_CYCLE_DIV - 1));
	wire raw_cycle = osc_running & osc_wrap;
	wire slow_wrap = (slow_div_reg == 3'(`PSWD_SD_DIV - 1));
	// Every derived tick divided by eight in slow-down
	wire cyc_tick = raw_cycle & (~slow_active | slow_wrap);
	// Slow-down request needs the gate pin low and no strap
	wire sd_req = power_control_reg[`PSWD_BIT_SD] & save_allowed;
	assign slow_active = sd_sync_reg[1];
	assign machine_cycle_tick = cyc_tick;

	// Dividers freeze when oscillator stops
	// Slow-down sync steps on raw cycles so it keeps running while slowed
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			osc_div_reg <= 4'h0;
			slow_div_reg <= 3'h0;
			sd_sync_reg <= 2'h0;
		end else begin
			if (osc_running) begin
				osc_div_reg <= osc_wrap ? 4'h0 : osc_div_reg + 4'h1;
			end
			if (raw_cycle) begin
				slow_div_reg <= slow_wrap ? 3'h0 : slow_div_reg + 3'h1;
				// Two raw cycles of sync; clear disengages same way
				sd_sync_reg <= {sd_sync_reg[0], sd_req};
			end
		end
	end

	// ======================================================
	// Power control and state
	// ======================================================
	// Two-write guard state for both saving modes
	logic pde_armed_reg; // Previous write set arm only
	logic idle_armed_reg; // Previous write set idle enable only
	wire w_pde = wbyte[`PSWD_BIT_PDE];
	wire w_pds = wbyte[`PSWD_BIT_PDS];
	wire w_idle = wbyte[`PSWD_BIT_IDLE];
	wire w_idle_start_bit = wbyte[`PSWD_BIT_IDLE_START_BIT];
	// Start only after a prior arm-only write, never together
	wire go_down = wr_power_control & w_pds & ~w_pde & pde_armed_reg & save_allowed;
	// Idle uses the same two-write pattern with its own pair of bits
	wire go_idle = wr_power_control & w_idle_start_bit & ~w_idle & idle_armed_reg & save_allowed;

	// Power-down wins over idle; only reset exits power-down
	always_comb begin
		pstate_next = pstate_reg;
		if (pstate_reg == PS_DOWN) begin
			pstate_next = PS_DOWN;
		end else if (go_down) begin
			pstate_next = PS_DOWN;
		end else if (go_idle) begin
			pstate_next = PS_IDLE;
		end
	end

	// Self-clearing bits are never stored, so they read zero
	// Arm flags live for one write; a read in between does not cancel them
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pstate_reg <= PS_RUN;
			power_control_reg <= 8'h00;
			pde_armed_reg <= 1'b0;
			idle_armed_reg <= 1'b0;
		end else begin
			pstate_reg <= pstate_next;
			if (wr_power_control) begin
				power_control_reg <= wbyte & `PSWD_POWER_CONTROL_KEEP;
				pde_armed_reg <= w_pde & ~w_pds;
				idle_armed_reg <= w_idle & ~w_idle_start_bit;
			end else if (wr_pend_reg) begin
				// Any other write breaks back-to-back sequence
				pde_armed_reg <= 1'b0;
				idle_armed_reg <= 1'b0;
			end
		end
	end

	// Pin-facing controls
	// Idle gates only the core clock; power-down also stops the oscillator
	always_comb begin
		pins.core_clk_en = (pstate_reg == PS_RUN);
		pins.osc_stop = (pstate_reg == PS_DOWN);
		pins.hold_outputs = (pstate_reg == PS_DOWN);
		pins.clock_output_pin_force_low = (pstate_reg == PS_DOWN);
		pins.ale_force_low = (pstate_reg == PS_DOWN);
		pins.program_store_strobe_force_low = (pstate_reg == PS_DOWN);
		pins.idle_active = (pstate_reg == PS_IDLE);
		pins.slow_active = slow_active;
	end

	// ======================================================
	// Watchdog
	// ======================================================
	logic [7:0] reload_reg; // Prescale select plus reload value
	logic [14:0] wd_count_reg; // 15-bit up-counter
	logic wd_run_reg; // Watchdog running
	logic [4:0] pre_reg; // Divide-by-2 then optional /16
	logic refresh_reg; // Refresh bit pending
	logic [1:0] refresh_age_reg; // Machine cycles since refresh set
	logic [7:0] wdrst_cnt_reg; // Internal reset length counter
	logic wdrst_reg; // Internal reset active
	logic autostart_go_reg; // Pending hardware start
	// Prescaler: divide by two always, by sixteen more when selected
	wire presc16 = reload_reg[`PSWD_BIT_PRESC];
	wire w_start = wr_wdctl & wbyte[`PSWD_BIT_START];
	wire w_refresh = wr_wdctl & wbyte[`PSWD_BIT_REFRESH];
	// Stopped while idle or power-down
	wire wd_tick_src = cyc_tick & (pstate_reg == PS_RUN);
	wire pre_limit = presc16 ? (pre_reg == 5'(`PSWD_PRE16 * 2 - 1)) : pre_reg[0];
	wire wd_inc = wd_run_reg & wd_tick_src & pre_limit & ~wdrst_reg;
	// Time-out raised on the tick that reaches the limit, so the internal
	// reset starts on a tick edge and spans whole machine cycles
	wire at_limit = (wd_count_reg == 15'(`PSWD_TIMEOUT - 1));
	wire timeout = wd_inc & at_limit;
	// Refresh needs the start bit while the refresh bit still stands
	wire do_reload = w_start & refresh_reg;
	wire sw_start = w_start & ~wd_run_reg;
	wire [14:0] load_val = {reload_reg[6:0], 8'h00};
	// Reset length counts down from one less than its cycle count
	wire [7:0] rst_len = presc16 ? 8'(`PSWD_RST_LONG - 1) : 8'(`PSWD_RST_SHORT - 1);
	assign watchdog_reset_out = wdrst_reg;

	// Reload register: cleared by every reset, writable except while the time-out reset is active
	// Bit 7 is stored as well, so the prescaler choice survives refreshes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			reload_reg <= 8'h00;
		end else if (wdrst_reg) begin
			reload_reg <= 8'h00;
		end else if (wr_reload) begin
			reload_reg <= wbyte;
		end
	end

	// Refresh bit lives for two machine cycles
	// A refresh left pending too long simply lapses; nothing else happens
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			refresh_reg <= 1'b0;
			refresh_age_reg <= 2'h0;
		end else if (w_refresh) begin
			refresh_reg <= 1'b1;
			refresh_age_reg <= 2'h0;
		end else if (do_reload) begin
			refresh_reg <= 1'b0;
		end else if (refresh_reg & cyc_tick) begin
			refresh_age_reg <= refresh_age_reg + 2'h1;
			if (refresh_age_reg == 2'(`PSWD_REFRESH_LIFE - 1)) begin
				refresh_reg <= 1'b0;
			end
		end
	end

	// Counter, prescaler, run flag and time-out reset
	// Priority: hardware start, software start, refresh, time-out, count
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wd_run_reg <= 1'b0;
			wd_count_reg <= 15'h0000;
			pre_reg <= 5'h00;
			wdrst_reg <= 1'b0;
			wdrst_cnt_reg <= 8'h00;
			autostart_go_reg <= 1'b0;
		end else begin
			autostart_go_reg <= ~strap_done_reg & powersave_gate_pin;
			if (autostart_go_reg & ~wd_run_reg) begin
				// Reload still at reset value: default period
				wd_run_reg <= 1'b1;
				wd_count_reg <= load_val;
				pre_reg <= 5'h00;
			end else if (sw_start) begin
				wd_run_reg <= 1'b1;
				wd_count_reg <= load_val;
				pre_reg <= 5'h00;
			end else if (do_reload & wd_run_reg) begin
				wd_count_reg <= load_val;
				pre_reg <= 5'h00;
			end else if (timeout) begin
				// Internal reset keeps the watchdog running
				wd_count_reg <= `PSWD_TIMEOUT;
				pre_reg <= 5'h00;
				wdrst_reg <= 1'b1;
				wdrst_cnt_reg <= rst_len;
			end else if (wdrst_reg) begin
				// Length counted in machine cycles, so slow-down stretches it
				if (cyc_tick) begin
					if (wdrst_cnt_reg == 8'h00) begin
						wdrst_reg <= 1'b0;
						wd_count_reg <= load_val;
						pre_reg <= 5'h00;
					end else begin
						wdrst_cnt_reg <= wdrst_cnt_reg - 8'h01;
					end
				end
			end else if (wd_run_reg & wd_tick_src) begin
				// Normal counting; frozen in idle and power-down
				pre_reg <= pre_limit ? 5'h00 : pre_reg + 5'h01;
				if (wd_inc) begin
					wd_count_reg <= wd_count_reg + 15'h0001;
				end
			end
		end
	end

	// ======================================================
	// Read mux
	// ======================================================
	// Decoded in the address phase so data stands in the data phase
	wire rd_power_control = (rd_addr == `PSWD_OFF_POWER_CONTROL);
	wire rd_reload = (rd_addr == `PSWD_OFF_RELOAD);
	wire rd_wdctl = (rd_addr == `PSWD_OFF_WDCTL);
	wire rd_status = (rd_addr == `PSWD_OFF_STATUS);
	wire rd_count = (rd_addr == `PSWD_OFF_COUNT);
	// Status: run, down, idle, slow, strap, time-out reset from bit 0 up
	wire [7:0] status_byte = {2'h0, wdrst_reg, hw_autostart_reg, slow_active,
		(pstate_reg == PS_IDLE), (pstate_reg == PS_DOWN), wd_run_reg};
	wire [31:0] rd_val = rd_power_control ? {24'h000000, power_control_reg} :
		rd_reload ? {24'h000000, reload_reg} :
		rd_wdctl ? {30'h00000000, wd_run_reg, refresh_reg} :
		rd_status ? {24'h000000, status_byte} :
		rd_count ? {17'h00000, wd_count_reg} : 32'h00000000;

	// Read data registered; appears in data phase
	// Held until the next read, so a late sampler still sees it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_reg <= 32'h00000000;
		end else if (rd_start) begin
			hrdata_reg <= rd_val;
		end
	end
endmodule

// ===== pswd_ctrl_monitor.sv
`timescale 1ns/100ps
`include "pswd_params.svh"
module pswd_ctrl_monitor (
	input wire logic hclk, // Clock
	input wire logic hresetn, // Reset, active low
	input wire pswd_pkg::pswd_ahb_req_type ahb_req, // Address phase
	input wire logic [31:0] hwdata, // Write data
	input wire logic [31:0] hrdata, // Read data
	input wire logic powersave_gate_pin, // Gate pin
	input wire pswd_pkg::pswd_pins_type pins, // Power outputs
	input wire logic machine_cycle_tick, // Cycle pulse
	input wire logic watchdog_reset_out // Time-out reset
);
	import pswd_pkg::*;
	// ====
	// Helper state
	logic wr_power_control; // POWER_CONTROL write in data phase
	logic rd_power_control; // POWER_CONTROL read in data phase
	logic strap; // Gate level seen at release
	logic strap_done; // Strap already taken
	logic tick_seen; // A first tick gives a gap origin
	logic slow_at_tick; // Slow state at the last tick
	logic [6:0] gap; // Clocks since last tick
	logic [13:0] hi_cnt; // Clocks of time-out reset
	wire take = ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready;
	wire at_power_control = ahb_req.haddr[7:0] == `PSWD_OFF_POWER_CONTROL;
	// Track bus phases and strap
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{wr_power_control, rd_power_control, strap, strap_done} <= 4'h0;
		end else begin
			wr_power_control <= take && at_power_control && ahb_req.hwrite;
			rd_power_control <= take && at_power_control && !ahb_req.hwrite;
			strap_done <= 1'b1;
			if (!strap_done) strap <= powersave_gate_pin;
		end
	end
	// Count gaps and reset length; the first gap after reset is skipped
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{tick_seen, slow_at_tick, gap, hi_cnt} <= 23'h0;
		end else begin
			gap <= machine_cycle_tick ? 7'h0 : gap + 7'h1;
			if (machine_cycle_tick) tick_seen <= 1'b1;
			if (machine_cycle_tick) slow_at_tick <= pins.slow_active;
			hi_cnt <= watchdog_reset_out ? hi_cnt + 14'h1 : 14'h0;
		end
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// ====
	// Checks
	a_down_pins_held:
	assert property (pins.osc_stop |-> pins.ale_force_low && pins.program_store_strobe_force_low
		&& pins.clock_output_pin_force_low && pins.hold_outputs && !pins.core_clk_en)
		else $error("power-down outputs wrong");
	a_down_stays:
	assert property (pins.osc_stop |=> pins.osc_stop) else $error("left power-down");
	a_gate_blocks_down:
	assert property (powersave_gate_pin [*3] ##0 !pins.osc_stop |=> !pins.osc_stop)
		else $error("power-down with gate high");
	a_tick_gap:
	assert property (machine_cycle_tick && tick_seen && slow_at_tick == pins.slow_active
		|-> gap == (pins.slow_active ? 7'h5F : 7'h0B)) else $error("cycle gap wrong");
	a_slow_engage:
	assert property (wr_power_control && hwdata[4] && !powersave_gate_pin && !strap && !pins.osc_stop
		|-> ##[1:26] pins.slow_active) else $error("slow-down late");
	a_strap_no_save:
	assert property (strap |-> !pins.slow_active && !pins.osc_stop && !pins.idle_active)
		else $error("saving with strap set");
	a_wdrst_length:
	assert property ($fell(watchdog_reset_out) |-> hi_cnt inside {14'h0060, 14'h0300,
		14'h0600, 14'h3000}) else $error("time-out reset length wrong");
	a_power_control_reads_zero:
	assert property (rd_power_control |-> hrdata[6:5] == 2'b00 && hrdata[1:0] == 2'b00)
		else $error("start bits read nonzero");
	// Main scenarios reached
	cover property ($rose(pins.osc_stop));
	cover property ($fell(watchdog_reset_out));
	cover property (machine_cycle_tick && pins.slow_active);
	cover property ($rose(pins.idle_active));
endmodule

// ===== pswd_supervisor_model.sv
`timescale 1ns/100ps
module pswd_supervisor_model (
	input wire logic hclk, // Clock
	input wire logic power_fail, // Supply warning
	output logic powersave_gate_pin // Gate to the controller
);
	// ====
	// Gate follows the warning one cycle late; a healthy supply
	// keeps saving blocked, as the weak pull-up would
	initial powersave_gate_pin = 1'b1;
	always @(posedge hclk) begin
		powersave_gate_pin <= !power_fail;
	end
endmodule

// ===== power_save_and_watchdog_ctrl_tb_top.sv
`timescale 1ns/100ps
`include "pswd_params.svh"
module power_save_and_watchdog_ctrl_tb_top;
	import pswd_pkg::*;
	// ====
	// Signals
	logic hclk, hresetn, hsel, hwrite, power_fail, hreadyout, hresp;
	logic powersave_gate_pin, machine_cycle_tick, watchdog_reset_out;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, hrdata, r;
	pswd_ahb_req_type ahb_req;
	pswd_pins_type pins;
	int n_fail, cmp_count, n;
	typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} pswd_row_type;
	pswd_row_type rows[5];
	assign ahb_req = '{hsel, haddr, htrans, hwrite, 3'b010, hreadyout};
	always #50 hclk = ~hclk;
	pswd_ctrl dut_u (.hclk(hclk), .hresetn(hresetn), .ahb_req(ahb_req), .hwdata(hwdata),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.powersave_gate_pin(powersave_gate_pin), .pins(pins),
		.machine_cycle_tick(machine_cycle_tick), .watchdog_reset_out(watchdog_reset_out));
	pswd_supervisor_model sup_u (.hclk(hclk), .power_fail(power_fail),
		.powersave_gate_pin(powersave_gate_pin));
	// ====
	// Tasks
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// One single transfer; read data lands in r
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= w;
		@(posedge hclk);
		while (!hreadyout) @(posedge hclk);
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge hclk);
		while (!hreadyout) @(posedge hclk);
		r = hrdata;
	endtask
	// Reset with the gate held at level g
	task automatic rst(input logic g);
		power_fail <= !g;
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
	endtask
	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// Hang guard, well above the longest expected run
	initial begin
		repeat (40000) @(posedge hclk);
		n_fail++;
		tally_and_finish();
	end
	// ====
	// Main sequence
	initial begin
		{hclk, hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
		{power_fail, n_fail, cmp_count} = '0;
		power_fail = 1'b1;
		rows = '{'{`PSWD_OFF_RELOAD, 32'h85, 32'h85}, '{`PSWD_OFF_RELOAD, 32'h2A, 32'h2A},
			'{`PSWD_OFF_POWER_CONTROL, 32'h8E, 32'h8C}, '{`PSWD_OFF_POWER_CONTROL, 32'h21, 32'h00},
			'{8'h30, 32'hFF, 32'h00}};
		rst(1'b0);
		xfer(0, `PSWD_OFF_RELOAD, 0);
		check("reload_rst", r, 32'h0);
		check("bus_resp", {30'h0, hreadyout, hresp}, 32'h2);
		foreach (rows[i]) begin
			xfer(1, rows[i].a, rows[i].d);
			xfer(0, rows[i].a, 0);
			check("row", r, rows[i].e);
		end
		// Slow-down in, its cycle length, and out
		xfer(1, `PSWD_OFF_POWER_CONTROL, 32'h10);
		n = 0;
		while (!pins.slow_active && n < 40) begin
			@(posedge hclk);
			n++;
		end
		check("slow_in", 32'(n <= 25), 32'h1);
		n = 0;
		do @(posedge hclk); while (!machine_cycle_tick);
		do begin
			@(posedge hclk);
			n++;
		end while (!machine_cycle_tick);
		check("slow_gap", n, `PSWD_SD_DIV * `PSWD_CYCLE_DIV);
		xfer(1, `PSWD_OFF_POWER_CONTROL, 0);
		repeat (30) @(posedge hclk);
		check("slow_out", 32'(pins.slow_active), 0);
		// Power-down: same write, gate high, then a proper entry with idle too
		xfer(1, `PSWD_OFF_POWER_CONTROL, 32'h42);
		repeat (30) @(posedge hclk);
		check("pd_same", 32'(pins.osc_stop), 0);
		power_fail <= 1'b0;
		repeat (3) @(posedge hclk);
		xfer(1, `PSWD_OFF_POWER_CONTROL, 32'h02);
		xfer(1, `PSWD_OFF_POWER_CONTROL, 32'h40);
		repeat (5) @(posedge hclk);
		check("pd_gate", 32'(pins.osc_stop), 0);
		power_fail <= 1'b1;
		repeat (3) @(posedge hclk);
		xfer(1, `PSWD_OFF_POWER_CONTROL, 32'h03);
		xfer(1, `PSWD_OFF_POWER_CONTROL, 32'h60);
		repeat (5) @(posedge hclk);
		check("pd_pins", 32'(pins), 32'h7C);
		rst(1'b0);
		check("pd_exit", 32'(pins), 32'h80);
		// Software start, time-out and its reset
		xfer(1, `PSWD_OFF_RELOAD, 32'h7F);
		xfer(1, `PSWD_OFF_WDCTL, 32'h02);
		xfer(0, `PSWD_OFF_STATUS, 0);
		check("wd_run", r & 32'h1, 32'h1);
		xfer(0, `PSWD_OFF_COUNT, 0);
		check("wd_load", (r >> 8) & 32'h7F, 32'h7F);
		xfer(1, `PSWD_OFF_WDCTL, 0);
		while (!watchdog_reset_out) @(posedge hclk);
		n = 0;
		while (watchdog_reset_out) begin
			@(posedge hclk);
			n++;
		end
		check("wd_rst_len", n, `PSWD_RST_SHORT * `PSWD_CYCLE_DIV);
		xfer(0, `PSWD_OFF_RELOAD, 0);
		check("wd_rel_clr", r, 32'h0);
		xfer(0, `PSWD_OFF_STATUS, 0);
		check("wd_keeps", r & 32'h1, 32'h1);
		// Strapped start: default period, saving locked out
		rst(1'b1);
		repeat (3) @(posedge hclk);
		xfer(0, `PSWD_OFF_STATUS, 0);
		check("auto_run", r & 32'h1, 32'h1);
		xfer(0, `PSWD_OFF_COUNT, 0);
		check("auto_def", (r >> 8) & 32'h7F, 32'h0);
		power_fail <= 1'b1;
		repeat (3) @(posedge hclk);
		xfer(1, `PSWD_OFF_POWER_CONTROL, 32'h10);
		repeat (30) @(posedge hclk);
		check("auto_slow", 32'(pins.slow_active), 0);
		xfer(1, `PSWD_OFF_POWER_CONTROL, 32'h02);
		xfer(1, `PSWD_OFF_POWER_CONTROL, 32'h40);
		repeat (5) @(posedge hclk);
		check("auto_pd", 32'(pins.osc_stop), 0);
		// Refresh pair reloads, a lapsed one does not, bit 7 adds /16
		xfer(1, `PSWD_OFF_RELOAD, 32'h55);
		xfer(1, `PSWD_OFF_WDCTL, 32'h01);
		xfer(1, `PSWD_OFF_WDCTL, 32'h02);
		xfer(0, `PSWD_OFF_COUNT, 0);
		check("refresh", (r >> 8) & 32'h7F, 32'h55);
		xfer(1, `PSWD_OFF_RELOAD, 32'h33);
		xfer(1, `PSWD_OFF_WDCTL, 32'h01);
		repeat (30) @(posedge hclk);
		xfer(0, `PSWD_OFF_WDCTL, 0);
		check("ref_lapse", r & 32'h1, 32'h0);
		xfer(1, `PSWD_OFF_WDCTL, 32'h02);
		xfer(0, `PSWD_OFF_COUNT, 0);
		check("ref_late", (r >> 8) & 32'h7F, 32'h55);
		xfer(1, `PSWD_OFF_RELOAD, 32'h80);
		xfer(1, `PSWD_OFF_WDCTL, 32'h01);
		xfer(1, `PSWD_OFF_WDCTL, 32'h02);
		repeat (300) @(posedge hclk);
		xfer(0, `PSWD_OFF_COUNT, 0);
		check("pre16", r, 32'h0);
		// Gate rising later starts nothing
		rst(1'b0);
		power_fail <= 1'b0;
		repeat (30) @(posedge hclk);
		xfer(0, `PSWD_OFF_STATUS, 0);
		check("gate_rise", r & 32'h1, 32'h0);
		// Idle alone: core clock gated, oscillator kept
		power_fail <= 1'b1;
		repeat (3) @(posedge hclk);
		xfer(1, `PSWD_OFF_POWER_CONTROL, 32'h01);
		xfer(1, `PSWD_OFF_POWER_CONTROL, 32'h20);
		repeat (5) @(posedge hclk);
		check("idle_pins", 32'(pins), 32'h02);
		tally_and_finish();
	end
endmodule
bind pswd_ctrl pswd_ctrl_monitor mon_u (.hclk(hclk), .hresetn(hresetn), .ahb_req(ahb_req),
	.hwdata(hwdata), .hrdata(hrdata), .powersave_gate_pin(powersave_gate_pin), .pins(pins),
	.machine_cycle_tick(machine_cycle_tick), .watchdog_reset_out(watchdog_reset_out));
